/* File: tucs_channel.sv */
/*
 * Timer unit channel setup: clock gate, prescaler selection and the
 * channel 0 mode register with a small counting engine behind it.
 * Assumes an Avalon-MM master on clock and an asynchronous timer pin.
 */
// Operation
// (RULE1) Clock gate bit 0 low stops the timer unit clock, high supplies it.
// (RULE2) Prescaler field n gives the first operation clock as system clock over 2^n.
// (RULE3) Bits 15:14 pick operation clock: 00 first, 01 third, 10 second, 11 fourth.
// (RULE4) Bit 12 low counts operation clock, high counts timer pin valid edges.
// (RULE5) Bit 11 high makes channel master, low independent or slave.
// (RULE6) Trigger field 000 allows software start only; software uses only 000,001,010,100.
// (RULE7) Trigger 001 uses the pin valid edge as start and capture trigger.
// (RULE8) Trigger 010 uses one pin edge to start, the other to capture.
// (RULE9) Trigger 100 starts the slave channel from the master interrupt.
// (RULE10) Interval or capture mode: low bit set raises interrupt and toggles output at start.
// (RULE11) One-count mode: low bit set accepts restart while counting, with interrupt.
// (RULE12) Fixed zero bits of mode and clock gate registers read zero, ignore writes.
`timescale 1ns/100ps
`include "tucs_defs.svh"

module tucs_channel
    import tucs_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic [`TUCS_AW-1:0]  avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 timer_input_pin,
    input  wire logic                 master_interrupt,
    output logic                      channel0_interrupt,
    output logic                      timer_output,
    output logic                      timer_unit_clock_enable,
    output logic                      channel_role,
    output logic                      irq
);

    tucs_top_s  s;
    tucs_top_s  next_s;
    logic [3:0] tick_vec;
    logic       op_tick;
    logic       count_tick;
    logic       rise;
    logic       fall;
    logic       valid_edge;
    logic       start_edge;
    logic       capt_edge;
    logic       wr;
    logic       sw_start;
    logic       sw_stop;
    logic       start;
    logic       capt_trig;
    logic       down;
    logic       ev;
    logic       ev_capt;
    logic [1:0] clr;
    logic [31:0] rd_mux;

    // The prescaler ticks only while the gate bit is set.
    tucs_prescaler u_presc (
        .clock  (clock),
        .rst    (rst),
        .enable (s.gate[`TUCS_GATE_BIT]),
        .sel_a  (s.presc[3:0]),
        .sel_b  (s.presc[7:4]),
        .sel_c  (s.presc[9:8]),
        .sel_d  (s.presc[13:12]),
        .tick   (tick_vec)
    );

    // Pin edges are taken from the filtered level, never the first sync stage.
    assign rise = s.pin_lvl & ~s.pin_prev;
    assign fall = ~s.pin_lvl & s.pin_prev;
    assign valid_edge = s.mode.edge_sel[1] ? (rise | fall) : (s.mode.edge_sel[0] ? rise : fall);
    assign start_edge = s.mode.edge_sel[0] ? rise : fall; // RULE8
    assign capt_edge  = s.mode.edge_sel[0] ? fall : rise; // RULE8

    // Codes 01 and 10 cross over: 01 picks the third clock.
    always_comb begin
        unique case (s.mode.op_clock_sel) // RULE3
            `TUCS_CLK_A: op_tick = tick_vec[0];
            `TUCS_CLK_C: op_tick = tick_vec[2];
            `TUCS_CLK_B: op_tick = tick_vec[1];
            `TUCS_CLK_D: op_tick = tick_vec[3];
        endcase
    end

    assign count_tick = s.mode.count_clock_source ? valid_edge : op_tick; // RULE4

    // A write lands where waitrequest is already low.
    assign wr       = avs_write & ~s.wreq;
    assign sw_start = wr && avs_address == `TUCS_OFS_CTRL && avs_writedata[`TUCS_CTRL_START];
    assign sw_stop  = wr && avs_address == `TUCS_OFS_CTRL && avs_writedata[`TUCS_CTRL_STOP];
    assign clr      = (wr && avs_address == `TUCS_OFS_ISTAT) ? avs_writedata[1:0] : 2'h0;

    always_comb begin
        start     = sw_start;
        capt_trig = 1'b0;
        // Prohibited trigger codes act as software only.
        case (s.mode.trigger_sel)
            `TUCS_TRIG_EDGE: begin
                start     = sw_start | valid_edge; // RULE7
                capt_trig = valid_edge; // RULE7
            end
            `TUCS_TRIG_BOTH: begin
                start     = sw_start | start_edge; // RULE8
                capt_trig = capt_edge; // RULE8
            end
            `TUCS_TRIG_MASTER: start = sw_start | master_interrupt; // RULE9
            default: start = sw_start; // RULE6
        endcase
    end

    // Capture modes count up, all others count down.
    assign down = s.mode.op_mode != `TUCS_OP_CAPTURE && s.mode.op_mode != `TUCS_OP_CAPT_ONE;

    // Unmapped addresses read as zero.
    always_comb begin
        rd_mux = `TUCS_RST_WORD;
        case (avs_address)
            `TUCS_OFS_GATE:   rd_mux = {24'h0, s.gate};
            `TUCS_OFS_PRESC:  rd_mux = {16'h0, s.presc};
            `TUCS_OFS_MODE:   rd_mux = {16'h0, s.mode};
            `TUCS_OFS_CTRL:   rd_mux = {29'h0, s.tout, s.pin_lvl, s.run == TUCS_RUN};
            `TUCS_OFS_PERIOD: rd_mux = {16'h0, s.period};
            `TUCS_OFS_CAPT:   rd_mux = {16'h0, s.capt};
            `TUCS_OFS_ISTAT:  rd_mux = {30'h0, s.istat};
            `TUCS_OFS_IMASK:  rd_mux = {30'h0, s.imask};
            `TUCS_OFS_COUNT:  rd_mux = {16'h0, s.cnt};
            default:          rd_mux = `TUCS_RST_WORD;
        endcase
    end

    always_comb begin
        next_s  = s;
        ev      = 1'b0;
        ev_capt = 1'b0;
        next_s.sync = {s.sync[1:0], timer_input_pin};
        if (s.sync[1] == s.sync[2]) begin
            next_s.pin_lvl = s.sync[2];
        end
        next_s.pin_prev = s.pin_lvl;
        next_s.chint    = 1'b0;

        // One wait state: the request is answered at the second edge.
        next_s.wreq = 1'b1;
        if ((avs_read | avs_write) && s.wreq) begin
            next_s.wreq  = 1'b0;
            next_s.rdata = rd_mux;
        end

        if (wr) begin
            case (avs_address)
                `TUCS_OFS_GATE:   next_s.gate = avs_writedata[7:0] & `TUCS_GATE_WMASK; // RULE12
                `TUCS_OFS_PRESC:  next_s.presc = avs_writedata[15:0] & `TUCS_PRESC_WMASK;
                `TUCS_OFS_MODE:   next_s.mode = avs_writedata[15:0] & `TUCS_MODE_WMASK; // RULE12
                `TUCS_OFS_PERIOD: next_s.period = avs_writedata[15:0];
                `TUCS_OFS_IMASK:  next_s.imask = avs_writedata[1:0];
                default: ;
            endcase
        end

        // The engine stands still while the gate is off.
        if (s.gate[`TUCS_GATE_BIT]) begin // RULE1
            if (s.run == TUCS_IDLE) begin
                if (start) begin
                    next_s.run = TUCS_RUN;
                    next_s.cnt = down ? s.period : `TUCS_ZERO16;
                    if (s.mode.mode_low_bit && (s.mode.op_mode == `TUCS_OP_INTERVAL
                        || s.mode.op_mode == `TUCS_OP_CAPTURE)) begin // RULE10
                        ev = 1'b1;
                    end
                end
            end else if (sw_stop) begin
                next_s.run = TUCS_IDLE;
            end else if (start && s.mode.op_mode == `TUCS_OP_ONECOUNT) begin
                if (s.mode.mode_low_bit) begin // RULE11
                    next_s.cnt = s.period;
                    ev = 1'b1;
                end
            end else if (capt_trig && !down) begin
                next_s.capt = s.cnt;
                next_s.cnt  = `TUCS_ZERO16;
                ev      = 1'b1;
                ev_capt = 1'b1;
                if (s.mode.op_mode == `TUCS_OP_CAPT_ONE) begin
                    next_s.run = TUCS_IDLE;
                end
            end else if (count_tick) begin
                if (!down) begin
                    next_s.cnt = s.cnt + 16'h0001;
                end else if (s.cnt == `TUCS_ZERO16) begin
                    ev = 1'b1;
                    next_s.cnt = s.period;
                    if (s.mode.op_mode == `TUCS_OP_ONECOUNT) begin
                        next_s.run = TUCS_IDLE;
                    end
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
        end

        if (ev) begin
            next_s.chint = 1'b1;
            next_s.tout  = ~s.tout;
        end

        // A status event in the clearing cycle survives the clear.
        next_s.istat = (s.istat & ~clr) | {ev_capt, ev};
        next_s.irq   = |(next_s.istat & next_s.imask);
    end

    // Waitrequest rests high through reset.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{gate: `TUCS_RST_GATE, presc: `TUCS_RST_REG16, mode: `TUCS_RST_REG16,
                   period: `TUCS_RST_REG16, cnt: `TUCS_RST_REG16, capt: `TUCS_RST_REG16,
                   istat: `TUCS_RST_INT, imask: `TUCS_RST_INT, run: TUCS_IDLE,
                   tout: 1'b0, chint: 1'b0, irq: 1'b0, sync: `TUCS_RST_SYNC,
                   pin_lvl: 1'b0, pin_prev: 1'b0, wreq: 1'b1, rdata: `TUCS_RST_WORD};
        end else begin
            s <= next_s;
        end
    end

    // Every output comes straight from a register.
    assign avs_readdata            = s.rdata;
    assign avs_waitrequest         = s.wreq;
    assign channel0_interrupt      = s.chint;
    assign timer_output            = s.tout;
    assign timer_unit_clock_enable = s.gate[`TUCS_GATE_BIT]; // RULE1
    assign channel_role            = s.mode.channel_role; // RULE5
    assign irq                     = s.irq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    gate_freeze_a: assert property (!s.gate[`TUCS_GATE_BIT] |=> $stable(s.cnt) && !channel0_interrupt) // RULE1
        else $error("Counter moved with the clock gate off.");

    op_clock_map_a: assert property (s.gate[`TUCS_GATE_BIT] && s.mode.op_clock_sel == `TUCS_CLK_C // RULE3
        && s.presc[9:8] == 2'h0 |=> op_tick || !$stable(s.mode.op_clock_sel))
        else $error("Operation clock select 01 does not pick the third clock.");

    pin_source_a: assert property (s.run == TUCS_RUN && s.mode.count_clock_source && !valid_edge // RULE4
        && s.mode.trigger_sel == `TUCS_TRIG_SW && !sw_stop && !sw_start |=> $stable(s.cnt))
        else $error("Counter moved without a pin edge.");

    role_write_a: assert property (wr && avs_address == `TUCS_OFS_MODE |=> // RULE5
        channel_role == $past(avs_writedata[11]))
        else $error("Channel role does not follow the mode write.");

    sw_only_a: assert property (s.run == TUCS_IDLE && s.mode.trigger_sel == `TUCS_TRIG_SW // RULE6
        && !sw_start |=> s.run == TUCS_IDLE)
        else $error("Channel started without a software trigger.");

    edge_start_a: assert property (s.run == TUCS_IDLE && s.gate[`TUCS_GATE_BIT] // RULE7
        && s.mode.trigger_sel == `TUCS_TRIG_EDGE && valid_edge |=> s.run == TUCS_RUN)
        else $error("Valid pin edge did not start the channel.");

    other_edge_a: assert property (s.run == TUCS_IDLE && s.mode.trigger_sel == `TUCS_TRIG_BOTH // RULE8
        && !start_edge && !sw_start |=> s.run == TUCS_IDLE)
        else $error("Capture edge started the channel.");

    master_start_a: assert property (s.run == TUCS_IDLE && s.gate[`TUCS_GATE_BIT] // RULE9
        && s.mode.trigger_sel == `TUCS_TRIG_MASTER && master_interrupt |=> s.run == TUCS_RUN)
        else $error("Master interrupt did not start the slave.");

    start_int_a: assert property (s.run == TUCS_IDLE && start && s.gate[`TUCS_GATE_BIT] // RULE10
        && s.mode.op_mode == `TUCS_OP_INTERVAL |=> channel0_interrupt == $past(s.mode.mode_low_bit)
        && timer_output != $past(timer_output) == $past(s.mode.mode_low_bit))
        else $error("Start interrupt does not follow the mode low bit.");

    restart_a: assert property (s.run == TUCS_RUN && start && !sw_stop && s.gate[`TUCS_GATE_BIT] // RULE11
        && s.mode.op_mode == `TUCS_OP_ONECOUNT && s.mode.mode_low_bit |=> channel0_interrupt
        && s.cnt == $past(s.period))
        else $error("One-count restart was not accepted.");

    no_restart_a: assert property (s.run == TUCS_RUN && sw_start && s.gate[`TUCS_GATE_BIT] // RULE11
        && s.mode.op_mode == `TUCS_OP_ONECOUNT && !s.mode.mode_low_bit |=> !channel0_interrupt)
        else $error("Ignored one-count restart raised an interrupt.");

    zero_bits_a: assert property (avs_read && avs_address == `TUCS_OFS_GATE && s.wreq // RULE12
        |=> avs_readdata[1] == 1'b0 && avs_readdata[6] == 1'b0)
        else $error("Fixed zero bit of the clock gate read as one.");

    mode_zero_a: assert property (avs_read && avs_address == `TUCS_OFS_MODE && s.wreq // RULE12
        |=> avs_readdata[13] == 1'b0 && avs_readdata[5:4] == 2'h0)
        else $error("Fixed zero bit of the mode register read as one.");

    irq_mask_a: assert property (wr && avs_address == `TUCS_OFS_IMASK && avs_writedata[1:0] == 2'h0
        |=> !irq)
        else $error("Interrupt stayed high with every bit masked.");

    // These show that a start, a capture and an interrupt clear are reached.
    run_cov: cover property (s.run == TUCS_IDLE ##1 s.run == TUCS_RUN ##[1:50] channel0_interrupt);

    capt_cov: cover property (ev_capt);

    irq_cov: cover property (irq ##1 !irq);

endmodule : tucs_channel

/* File: tucs_defs.svh */
/*
 * Register map, field positions, reset values and mode codes of the
 * timer unit channel setup block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`ifndef TUCS_DEFS_SVH
`define TUCS_DEFS_SVH

`define TUCS_AW            6
`define TUCS_OFS_GATE      6'h00
`define TUCS_OFS_PRESC     6'h04
`define TUCS_OFS_MODE      6'h08
`define TUCS_OFS_CTRL      6'h0C
`define TUCS_OFS_PERIOD    6'h10
`define TUCS_OFS_CAPT      6'h14
`define TUCS_OFS_ISTAT     6'h18
`define TUCS_OFS_IMASK     6'h1C
`define TUCS_OFS_COUNT     6'h20

`define TUCS_GATE_BIT      0
`define TUCS_GATE_WMASK    8'hBD
`define TUCS_PRESC_WMASK   16'h33FF
`define TUCS_MODE_WMASK    16'hDFCF

`define TUCS_CTRL_START    0
`define TUCS_CTRL_STOP     1

`define TUCS_RST_GATE      8'h00
`define TUCS_RST_REG16     16'h0000
`define TUCS_RST_INT       2'h0
`define TUCS_RST_SYNC      3'h0
`define TUCS_RST_WORD      32'h0000_0000
`define TUCS_ZERO16        16'h0000

`define TUCS_IRQ_EVENT     0
`define TUCS_IRQ_CAPT      1

`define TUCS_CLK_A         2'h0
`define TUCS_CLK_C         2'h1
`define TUCS_CLK_B         2'h2
`define TUCS_CLK_D         2'h3

`define TUCS_TRIG_SW       3'h0
`define TUCS_TRIG_EDGE     3'h1
`define TUCS_TRIG_BOTH     3'h2
`define TUCS_TRIG_MASTER   3'h4

`define TUCS_OP_INTERVAL   3'h0
`define TUCS_OP_CAPTURE    3'h2
`define TUCS_OP_EVENT      3'h3
`define TUCS_OP_ONECOUNT   3'h4
`define TUCS_OP_CAPT_ONE   3'h6

`define TUCS_PRESC_W       15
`define TUCS_PRESC_ONES    15'h7FFF
`define TUCS_PRESC_ZERO    15'h0000

`endif

/* File: tucs_pkg.sv */
/*
 * Types of the timer unit channel setup block.
 * Assumes tucs_defs.svh is available on the include path.
 */
package tucs_pkg;

    typedef enum logic {TUCS_IDLE, TUCS_RUN} tucs_run_e;

    typedef struct packed {
        logic [1:0] op_clock_sel;
        logic       zero13;
        logic       count_clock_source;
        logic       channel_role;
        logic [2:0] trigger_sel;
        logic [1:0] edge_sel;
        logic [1:0] zero54;
        logic [2:0] op_mode;
        logic       mode_low_bit;
    } tucs_mode_s;

    typedef struct packed {
        logic [14:0] cnt;
        logic [3:0]  tick;
    } tucs_presc_s;

    typedef struct packed {
        logic [7:0]  gate;
        logic [15:0] presc;
        tucs_mode_s  mode;
        logic [15:0] period;
        logic [15:0] cnt;
        logic [15:0] capt;
        logic [1:0]  istat;
        logic [1:0]  imask;
        tucs_run_e   run;
        logic        tout;
        logic        chint;
        logic        irq;
        logic [2:0]  sync;
        logic        pin_lvl;
        logic        pin_prev;
        logic        wreq;
        logic [31:0] rdata;
    } tucs_top_s;

endpackage : tucs_pkg

/* File: tucs_prescaler.sv */
/*
 * Prescaler: one free-running counter gives four operation clock
 * enables, each the system clock divided by two to the selected power.
 * Assumes selects come from registers on the same clock.
 */
`timescale 1ns/100ps
`include "tucs_defs.svh"

module tucs_prescaler
    import tucs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic [3:0] sel_a,
    input  wire logic [3:0] sel_b,
    input  wire logic [1:0] sel_c,
    input  wire logic [1:0] sel_d,
    output logic [3:0]      tick
);

    tucs_presc_s s;
    tucs_presc_s next_s;
    logic [3:0]  sel [4];
    logic [3:0]  hit;

    assign sel[0] = sel_a;
    assign sel[1] = sel_b;
    assign sel[2] = {2'h0, sel_c};
    assign sel[3] = {2'h0, sel_d};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_tick
            logic [14:0] mask;
            assign mask   = ~(`TUCS_PRESC_ONES << sel[i]);
            assign hit[i] = ((s.cnt & mask) == mask); // RULE2
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.tick = enable ? hit : 4'h0; // RULE1
        if (enable) begin
            next_s.cnt = s.cnt + 15'h0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{cnt: `TUCS_PRESC_ZERO, tick: 4'h0};
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    div_one_a: assert property (enable && sel_a == 4'h0 |=> tick[0]) // RULE2
        else $error("Divide by one does not tick every cycle.");
    div_two_a: assert property (enable && sel_a == 4'h1 && $stable(sel_a) && tick[0] |=> !tick[0]) // RULE2
        else $error("Divide by two ticks twice in a row.");

endmodule : tucs_prescaler

/* File: tb_tucs_channel.sv */
/*
 * Self-checking bench for tucs_channel: register access, prescaler rates,
 * clock selection, trigger sources, interrupt status, mask and clearing.
 * Assumes tucs_defs.svh and tucs_pkg are compiled before it.
 */
`timescale 1ns/100ps
`include "tucs_defs.svh"

module tb_tucs_channel
    import tucs_pkg::*;
();
    logic                clock;
    logic                rst;
    logic [`TUCS_AW-1:0] avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                timer_input_pin;
    logic                master_interrupt;
    logic                channel0_interrupt;
    logic                timer_output;
    logic                timer_unit_clock_enable;
    logic                channel_role;
    logic                irq;
    logic [31:0]         rd;
    int                  n_fail = 0;
    int                  checked = 0;
    int                  n_int = 0;
    int                  cyc = 0;
    int                  t_prev = 0;
    int                  t_last = 0;

    tucs_channel i_tucs_channel (
        .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_input_pin(timer_input_pin),
        .master_interrupt(master_interrupt), .channel0_interrupt(channel0_interrupt),
        .timer_output(timer_output), .timer_unit_clock_enable(timer_unit_clock_enable),
        .channel_role(channel_role), .irq(irq));

    initial clock = 1'b0;
    always #10 clock = ~clock;

    // Counts interrupt pulses and keeps the times of the last two.
    always @(posedge clock) begin
        cyc++;
        if (channel0_interrupt === 1'b1) begin
            n_int++;
            t_prev = t_last;
            t_last = cyc;
        end
    end

    function automatic logic [31:0] mode_word(input logic [1:0] osel, input logic ccs, input logic [2:0] trig,
                                              input logic [1:0] edg, input logic [3:0] md);
        return {16'h0, osel, 1'b0, ccs, 1'b0, trig, edg, 2'b00, md};
    endfunction : mode_word

    function automatic int sel_exp(input logic [1:0] s, input logic [15:0] p);
        case (s)
            2'h0: return p[3:0];
            2'h1: return p[9:8];
            2'h2: return p[7:4];
            default: return p[13:12];
        endcase
    endfunction : sel_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        if (n >= 100) check(32'h0, 32'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        check(rd, e);
    endtask : rd_chk

    task automatic run_is(input logic e);
        bus(1'b0, `TUCS_OFS_CTRL, 32'h0, rd);
        check({31'h0, rd[0]}, {31'h0, e});
    endtask : run_is

    task automatic do_reset;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask : do_reset

    task automatic setup(input logic [31:0] p, input logic [31:0] m, input logic [31:0] per);
        wr(`TUCS_OFS_GATE, 32'h1);
        wr(`TUCS_OFS_PRESC, p);
        wr(`TUCS_OFS_PERIOD, per);
        wr(`TUCS_OFS_MODE, m);
    endtask : setup

    task automatic pin_to(input logic v);
        timer_input_pin <= v;
        repeat (8) @(posedge clock);
    endtask : pin_to

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge clock);
        check(32'h0, 32'h1);
        tally_and_finish;
    end

    initial begin
        int          s;
        int          c0;
        logic [31:0] d;
        logic [15:0] p;
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        timer_input_pin = 1'b0;
        master_interrupt = 1'b0;
        void'($urandom(37));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({31'h0, avs_waitrequest}, 32'h1);
        for (int a = 0; a <= 8; a++) rd_chk(6'(a * 4), 32'h0);
        done("reset");
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
            wr(`TUCS_OFS_GATE, d);
            rd_chk(`TUCS_OFS_GATE, d & 32'hBD);
            check({31'h0, timer_unit_clock_enable}, {31'h0, d[0]});
            wr(`TUCS_OFS_PRESC, d);
            rd_chk(`TUCS_OFS_PRESC, d & 32'h33FF);
            d[9]  = d[9] & ~d[8];
            d[10] = d[10] & ~d[9] & ~d[8];
            wr(`TUCS_OFS_MODE, d);
            rd_chk(`TUCS_OFS_MODE, d & 32'hDFCF);
            check({31'h0, channel_role}, {31'h0, d[11]});
            wr(6'h3C, d);
            rd_chk(6'h3C, 32'h0);
        end
        done("registers");
        for (int i = 0; i < 8; i++) begin
            p = {2'b00, 2'($urandom), 2'b00, 2'($urandom), 4'($urandom_range(5)), (i == 0) ? 4'h0 : 4'($urandom_range(5))};
            do_reset;
            setup({16'h0, p}, mode_word(2'(i), 1'b0, `TUCS_TRIG_SW, 2'b00, 4'h0), 32'h3);
            wr(`TUCS_OFS_CTRL, 32'h1);
            s = n_int;
            for (int k = 0; k < 5000 && n_int < s + 3; k++) @(posedge clock);
            check(32'(t_last - t_prev), 32'(4 << sel_exp(2'(i), p)));
        end
        done("prescaler");
        for (int i = 0; i < 4; i++) begin
            do_reset;
            setup(32'h0, mode_word(2'b00, 1'b0, `TUCS_TRIG_SW, 2'b00,
                  {i[1] ? `TUCS_OP_CAPTURE : `TUCS_OP_INTERVAL, i[0]}), 32'hFFF);
            s = n_int;
            wr(`TUCS_OFS_CTRL, 32'h1);
            repeat (10) @(posedge clock);
            check(32'(n_int - s), 32'(i[0]));
            check({31'h0, timer_output}, 32'(i[0]));
        end
        done("start interrupt");
        for (int i = 0; i < 2; i++) begin
            do_reset;
            setup(32'h0, mode_word(2'b00, 1'b0, `TUCS_TRIG_SW, 2'b00, {`TUCS_OP_ONECOUNT, i[0]}), 32'hFFF);
            wr(`TUCS_OFS_CTRL, 32'h1);
            run_is(1'b1);
            s = n_int;
            wr(`TUCS_OFS_CTRL, 32'h1);
            repeat (10) @(posedge clock);
            check(32'(n_int - s), 32'(i[0]));
        end
        done("one count");
        for (int i = 0; i < 2; i++) begin
            do_reset;
            setup(32'h0, mode_word(2'b00, 1'b0, i[0] ? `TUCS_TRIG_EDGE : `TUCS_TRIG_SW, 2'b01,
                  {`TUCS_OP_INTERVAL, 1'b1}), 32'hFFF);
            s = n_int;
            pin_to(1'b1);
            check(32'(n_int - s), 32'(i[0]));
            run_is(i[0]);
            pin_to(1'b0);
        end
        done("pin trigger");
        do_reset;
        setup(32'h0, mode_word(2'b00, 1'b0, `TUCS_TRIG_BOTH, 2'b11, {`TUCS_OP_CAPTURE, 1'b0}), 32'hFFF);
        wr(`TUCS_OFS_IMASK, 32'h2);
        c0 = cyc;
        pin_to(1'b1);
        run_is(1'b1);
        rd_chk(`TUCS_OFS_ISTAT, 32'h0);
        c0 = cyc - c0;
        pin_to(1'b0);
        bus(1'b0, `TUCS_OFS_CAPT, 32'h0, rd);
        check({31'h0, (rd >= 32'(c0 - 2) && rd <= 32'(c0 + 2))}, 32'h1);
        bus(1'b0, `TUCS_OFS_ISTAT, 32'h0, rd);
        check(rd & 32'h2, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr(`TUCS_OFS_IMASK, 32'h0);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        wr(`TUCS_OFS_IMASK, 32'h2);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        wr(`TUCS_OFS_ISTAT, 32'h2);
        bus(1'b0, `TUCS_OFS_ISTAT, 32'h0, rd);
        check(rd & 32'h2, 32'h0);
        check({31'h0, irq}, 32'h0);
        done("capture");
        do_reset;
        setup(32'h0, mode_word(2'b00, 1'b0, `TUCS_TRIG_MASTER, 2'b00, {`TUCS_OP_INTERVAL, 1'b1}), 32'hFFF);
        s = n_int;
        repeat (5) @(posedge clock);
        check(32'(n_int - s), 32'h0);
        master_interrupt <= 1'b1;
        @(posedge clock);
        master_interrupt <= 1'b0;
        repeat (6) @(posedge clock);
        check(32'(n_int - s), 32'h1);
        run_is(1'b1);
        done("master start");
        do_reset;
        setup(32'h0, mode_word(2'b00, 1'b1, `TUCS_TRIG_SW, 2'b01, {`TUCS_OP_EVENT, 1'b0}), 32'h2);
        wr(`TUCS_OFS_CTRL, 32'h1);
        s = n_int;
        for (int k = 0; k < 3; k++) begin
            check(32'(n_int - s), 32'h0);
            pin_to(1'b1);
            pin_to(1'b0);
        end
        check(32'(n_int - s), 32'h1);
        done("pin count");
        do_reset;
        wr(`TUCS_OFS_PERIOD, 32'h3);
        wr(`TUCS_OFS_MODE, mode_word(2'b00, 1'b0, `TUCS_TRIG_SW, 2'b00, {`TUCS_OP_INTERVAL, 1'b1}));
        s = n_int;
        wr(`TUCS_OFS_CTRL, 32'h1);
        repeat (10) @(posedge clock);
        check(32'(n_int - s), 32'h0);
        run_is(1'b0);
        wr(`TUCS_OFS_GATE, 32'h1);
        repeat (2) @(posedge clock);
        check({31'h0, timer_unit_clock_enable}, 32'h1);
        s = n_int;
        wr(`TUCS_OFS_CTRL, 32'h1);
        repeat (10) @(posedge clock);
        check({31'h0, n_int > s}, 32'h1);
        done("clock gate");
        tally_and_finish;
    end
endmodule : tb_tucs_channel
